// ==== strx_pkg.sv ====
// Shared constants, register map and default taps for the sample timing block
package strx_pkg;
    // Timing ratios relative to the 20 MHz master clock
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned BIT_DIV = 4;
    localparam int unsigned SMP_DIV = 64;
    localparam int unsigned SYM_DIV = 8;
    localparam int unsigned NTAP = 63;
    localparam logic [5:0] SMP_LAST = 6'(SMP_DIV - 1);
    localparam logic [1:0] BIT_LAST = 2'(BIT_DIV - 1);
    localparam logic [5:0] TAP_LAST = 6'(NTAP - 1);
    localparam logic [2:0] SYM_HALF = 3'(SYM_DIV / 2);

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PHASE = 8'h04;
    localparam logic [7:0] OFS_DAC_I = 8'h08;
    localparam logic [7:0] OFS_DAC_Q = 8'h0C;
    localparam logic [7:0] OFS_TXD_I = 8'h10;
    localparam logic [7:0] OFS_TXD_Q = 8'h14;
    localparam logic [7:0] OFS_RXO_I = 8'h18;
    localparam logic [7:0] OFS_RXO_Q = 8'h1C;
    localparam logic [7:0] OFS_GAIN_I = 8'h20;
    localparam logic [7:0] OFS_GAIN_Q = 8'h24;
    localparam logic [7:0] OFS_CPTR = 8'h28;
    localparam logic [7:0] OFS_CDAT = 8'h2C;
    localparam logic [7:0] OFS_STAT = 8'h30;

    // Control, pointer and status register bit positions
    localparam int unsigned CTRL_IDENT = 0;
    localparam int unsigned CTRL_SYM_IRQ = 1;
    localparam int unsigned CTRL_AAF_BYP = 2;
    localparam int unsigned CTRL_DAC_TEST = 3;
    localparam int unsigned CTRL_RX_EN = 4;
    localparam int unsigned CTRL_TX_DIRECT = 5;
    localparam int unsigned CPTR_STAGE = 8;
    localparam int unsigned STAT_PEND = 3;

    // Phase codes: bit 2 retards, bits 1:0 eighths of a symbol
    localparam logic [2:0] PH_NONE = 3'h0;
    localparam logic [2:0] PH_ADV_8 = 3'h1;
    localparam logic [2:0] PH_ADV_4 = 3'h2;
    localparam logic [2:0] PH_RET_8 = 3'h5;
    localparam logic [2:0] PH_RET_4 = 3'h6;

    // Reset values
    localparam logic [15:0] GAIN_RST = 16'h7FFF;
    localparam logic [7:0] CTRL_RST = 8'h00;

    // Half of a symmetric root raised cosine, alpha 0.35, index 0 = centre
    localparam logic [31:0][15:0] RRC_HALF = {
        16'h0000, 16'h0000, 16'hFFAE, 16'hFF5C,
        16'hFF0A, 16'hFF0A, 16'hFF5C, 16'hFFAE,
        16'h0000, 16'h00A4, 16'h0148, 16'h019A,
        16'h01EC, 16'h019A, 16'h00F6, 16'h0000,
        16'hFF0A, 16'hFDC3, 16'hFC7B, 16'hFB85,
        16'hFB33, 16'hFB85, 16'hFCCD, 16'hFF0A,
        16'h03D7, 16'h0852, 16'h0D71, 16'h12E1,
        16'h1800, 16'h1C29, 16'h1F0A, 16'h2000};

    // Expands the half table into all taps
    function automatic logic [62:0][15:0] rrc_all();
        logic [62:0][15:0] t;
        t = '0;
        for (int k = 0; k < 63; k++) begin
            t[k] = RRC_HALF[(k < 31) ? (31 - k) : (k - 31)];
        end
        return t;
    endfunction
    localparam logic [62:0][15:0] RRC_DEFAULT = rrc_all();
endpackage

// ==== strx_smp_if.sv ====
// Sample stream carrier between datapath stages
`timescale 1ns/10ps
interface strx_smp_if;
    logic vld; // One-cycle sample pulse
    logic [15:0] i; // I sample, two's complement
    logic [15:0] q; // Q sample, two's complement
    modport src(output vld, output i, output q);
    modport dst(input vld, input i, input q);
endinterface

// ==== strx_fir.sv ====
// One programmable 63-tap FIR stage for I and Q with shared taps
`timescale 1ns/10ps
module strx_fir (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic coef_we_i,
    input wire logic [5:0] coef_idx_i,
    input wire logic [15:0] coef_dat_i,
    strx_smp_if.dst in_if,
    strx_smp_if.src out_if
);
    typedef struct packed {
        logic [62:0][15:0] coef; // Tap RAM
        logic [62:0][15:0] di; // I history, 0 newest
        logic [62:0][15:0] dq; // Q history
        logic [5:0] idx; // MAC pointer
        logic busy; // MAC running
        logic signed [39:0] ai;
        logic signed [39:0] aq;
        logic vld;
        logic [15:0] oi;
        logic [15:0] oq;
    } strx_fir_st_t;

    strx_fir_st_t s_q, s_d;

    // Signed multiply-accumulate of one tap
    function automatic logic signed [39:0] mac(input logic signed [39:0] a,
        input logic [15:0] d, input logic [15:0] c);
        logic signed [31:0] p;
        p = signed'(d) * signed'(c);
        return a + 40'(p);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Serial MAC: 63 cycles fit inside one 64-cycle sample period
    always_comb begin
        s_d = s_q;
        s_d.vld = 1'b0;
        if (coef_we_i) begin
            s_d.coef[coef_idx_i] = coef_dat_i;
        end
        if (s_q.busy) begin
            s_d.ai = mac(s_q.ai, s_q.di[s_q.idx], s_q.coef[s_q.idx]);
            s_d.aq = mac(s_q.aq, s_q.dq[s_q.idx], s_q.coef[s_q.idx]);
            s_d.idx = s_q.idx + 6'h01;
            if (s_q.idx == strx_pkg::TAP_LAST) begin
                // Q1.15 taps: drop the fraction bits
                s_d.busy = 1'b0;
                s_d.vld = 1'b1;
                s_d.oi = s_d.ai[30:15];
                s_d.oq = s_d.aq[30:15];
            end
        end
        if (in_if.vld) begin
            // New sample restarts the sum; earlier one is always done
            s_d.di = {s_q.di[61:0], in_if.i};
            s_d.dq = {s_q.dq[61:0], in_if.q};
            s_d.idx = 6'h00;
            s_d.busy = 1'b1;
            s_d.ai = '0;
            s_d.aq = '0;
        end
    end

    // State register; taps return to the default response
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            s_q <= '0;
            s_q.coef <= strx_pkg::RRC_DEFAULT;
        end else begin
            s_q <= s_d;
        end
    end

    assign out_if.vld = s_q.vld;
    assign out_if.i = s_q.oi;
    assign out_if.q = s_q.oq;
endmodule

// ==== strx_top.sv ====
// Sample timing, DAC test access and receive datapath with register slave
//
// Contract
// - Phase writes shift symbol clock 1/8 or 1/4
// - Symbol clock can drive the interrupt pin
// - Ident mode puts symbol clock in I LSB
// - Direct I/Q writes feed transmit filter per symbol
// - DAC input samples writable and readable by host
// - DAC sample moves at next sample clock
// - Symbol clock is sample clock divided by eight
// - Receive modulators sample at 128x symbol rate
// - One-bit streams decimated from MCLK/4 to MCLK/64
// - Decimator coefficients are fixed
// - Two cascaded 63-tap FIR stages per channel
// - Reset taps give RRC alpha 0.35
// - Programmed offset subtracted from receive data
// - Signed gain; negative inverts the channel
// - I and Q gains held independently
// - Anti-alias filter bypass and power-down control
// - Serial words 16-bit, I first, MSB first
//
// The address map and the Avalon-MM slave port were decided locally.
`timescale 1ns/10ps
module strx_top (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic rx_bit_i_i,
    input wire logic rx_bit_q_i,
    output logic rx_sclk_o,
    output logic rx_dat_o,
    output logic rx_fs_o,
    output logic irq_b_o,
    output logic aaf_bypass_o,
    output logic aaf_pdn_o,
    output logic [15:0] dac_i_o,
    output logic [15:0] dac_q_o,
    output logic dac_vld_o,
    output logic [15:0] txf_i_o,
    output logic [15:0] txf_q_o,
    output logic txf_vld_o
);
    // Sinc2 decimator state of one channel
    typedef struct packed {
        logic signed [11:0] i1, i2, d1, d2, y;
    } strx_dec_t;

    typedef struct packed {
        logic wreq; // Waitrequest, high when idle
        logic [31:0] rdata;
        logic [7:0] ctrl;
        logic [2:0] phase; // Pending adjustment code
        logic [5:0] smp_cnt; // Master clocks within a sample
        logic [2:0] sym_cnt; // Samples within a symbol
        logic [15:0] dac_st_i, dac_st_q; // Staged test samples
        logic [15:0] dac_i, dac_q;
        logic dac_vld;
        logic [15:0] txd_i, txd_q, txf_i, txf_q;
        logic txf_vld;
        logic [15:0] ofs_i, ofs_q, gain_i, gain_q;
        logic [8:0] cptr;
        logic cwe1, cwe2;
        logic [5:0] cidx;
        logic [15:0] cdat;
        strx_dec_t dec_i, dec_q;
        logic dec_vld;
        logic [31:0] sh; // Serial shift register
        logic [5:0] bits; // Bits left to send
        logic sclk, rdat, rfs, irq_b;
    } strx_st_t;

    strx_st_t s_q, s_d;
    logic smp_stb, bit_stb, sym_lvl, bus_done;
    strx_smp_if dec_if ();
    strx_smp_if f1_if ();
    strx_smp_if f2_if ();

    // Merges the enabled low byte lanes into a 16-bit register
    function automatic logic [15:0] be16(input logic [15:0] old,
        input logic [31:0] wd, input logic [3:0] be);
        return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    // Integrates one modulator bit as +1 or -1
    function automatic strx_dec_t dec_int(input strx_dec_t d,
        input logic b);
        strx_dec_t r;
        r = d;
        r.i1 = d.i1 + (b ? 12'sh001 : 12'shFFF);
        r.i2 = d.i2 + r.i1;
        return r;
    endfunction

    // Comb section at the decimated rate
    function automatic strx_dec_t dec_comb(input strx_dec_t d);
        strx_dec_t r;
        logic signed [11:0] c1;
        r = d;
        c1 = d.i2 - d.d1;
        r.y = c1 - d.d2;
        r.d1 = d.i2;
        r.d2 = c1;
        return r;
    endfunction

    // Offset removal then signed Q1.15 gain
    function automatic logic [15:0] corr(input logic [15:0] x,
        input logic [15:0] ofs, input logic [15:0] g);
        logic signed [16:0] dlt;
        logic signed [33:0] p;
        dlt = 17'(signed'(x)) - 17'(signed'(ofs));
        p = 34'(dlt) * 34'(signed'(g));
        return p[30:15];
    endfunction

    // Timing strobes decoded from the counters
    assign smp_stb = (s_q.smp_cnt == strx_pkg::SMP_LAST);
    assign bit_stb = (s_q.smp_cnt[1:0] == strx_pkg::BIT_LAST);
    assign sym_lvl = (s_q.sym_cnt < strx_pkg::SYM_HALF);
    assign bus_done = !s_q.wreq && (avs_read_i || avs_write_i);

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic for bus, timing, DAC test and receive output
    always_comb begin
        s_d = s_q;
        s_d.wreq = 1'b1;
        s_d.dac_vld = 1'b0;
        s_d.txf_vld = 1'b0;
        s_d.cwe1 = 1'b0;
        s_d.cwe2 = 1'b0;
        s_d.dec_vld = 1'b0;
        // Sample counter never moves on a phase write
        s_d.smp_cnt = s_q.smp_cnt + 6'h01;
        if (smp_stb) begin
            // Whole-sample slips; a quarter retard holds on two strobes
            case (s_q.phase)
                strx_pkg::PH_ADV_8: s_d.sym_cnt = s_q.sym_cnt + 3'h2;
                strx_pkg::PH_ADV_4: s_d.sym_cnt = s_q.sym_cnt + 3'h3;
                strx_pkg::PH_RET_8: s_d.sym_cnt = s_q.sym_cnt;
                strx_pkg::PH_RET_4: s_d.sym_cnt = s_q.sym_cnt;
                default: s_d.sym_cnt = s_q.sym_cnt + 3'h1;
            endcase
            s_d.phase = (s_q.phase == strx_pkg::PH_RET_4) ?
                strx_pkg::PH_RET_8 : strx_pkg::PH_NONE;
            // Test samples move over on this strobe only
            if (s_q.ctrl[strx_pkg::CTRL_DAC_TEST]) begin
                s_d.dac_i = s_q.dac_st_i;
                s_d.dac_q = s_q.dac_st_q;
                s_d.dac_vld = 1'b1;
            end
            // Direct filter input once per symbol
            if (s_q.sym_cnt == 3'h0 &&
                s_q.ctrl[strx_pkg::CTRL_TX_DIRECT]) begin
                s_d.txf_i = s_q.txd_i;
                s_d.txf_q = s_q.txd_q;
                s_d.txf_vld = 1'b1;
            end
            s_d.dec_i = dec_comb(s_q.dec_i);
            s_d.dec_q = dec_comb(s_q.dec_q);
            s_d.dec_vld = 1'b1;
        end
        if (bit_stb) begin
            s_d.dec_i = dec_int(s_d.dec_i, rx_bit_i_i);
            s_d.dec_q = dec_int(s_d.dec_q, rx_bit_q_i);
        end
        // Bus: one wait state, answer when waitrequest drops
        if ((avs_read_i || avs_write_i) && s_q.wreq) begin
            s_d.wreq = 1'b0;
            s_d.rdata = '0;
            case (avs_address_i)
                strx_pkg::OFS_CTRL: s_d.rdata[7:0] = s_q.ctrl;
                strx_pkg::OFS_PHASE: s_d.rdata[2:0] = s_q.phase;
                strx_pkg::OFS_DAC_I: s_d.rdata[15:0] = s_q.dac_i;
                strx_pkg::OFS_DAC_Q: s_d.rdata[15:0] = s_q.dac_q;
                strx_pkg::OFS_TXD_I: s_d.rdata[15:0] = s_q.txd_i;
                strx_pkg::OFS_TXD_Q: s_d.rdata[15:0] = s_q.txd_q;
                strx_pkg::OFS_RXO_I: s_d.rdata[15:0] = s_q.ofs_i;
                strx_pkg::OFS_RXO_Q: s_d.rdata[15:0] = s_q.ofs_q;
                strx_pkg::OFS_GAIN_I: s_d.rdata[15:0] = s_q.gain_i;
                strx_pkg::OFS_GAIN_Q: s_d.rdata[15:0] = s_q.gain_q;
                strx_pkg::OFS_CPTR: s_d.rdata[8:0] = s_q.cptr;
                strx_pkg::OFS_STAT: begin
                    s_d.rdata[2:0] = s_q.sym_cnt;
                    s_d.rdata[strx_pkg::STAT_PEND] = |s_q.phase;
                end
                default: s_d.rdata = '0; // Unmapped reads zero
            endcase
        end
        if (bus_done && avs_write_i) begin
            case (avs_address_i)
                strx_pkg::OFS_CTRL: begin
                    if (avs_byteenable_i[0]) begin
                        s_d.ctrl = avs_writedata_i[7:0];
                    end
                end
                // A new write replaces any code not yet applied
                strx_pkg::OFS_PHASE: begin
                    if (avs_byteenable_i[0]) begin
                        s_d.phase = avs_writedata_i[2:0];
                    end
                end
                // Host keeps bytes of one sample in one period
                strx_pkg::OFS_DAC_I: s_d.dac_st_i = be16(s_q.dac_st_i,
                    avs_writedata_i, avs_byteenable_i);
                strx_pkg::OFS_DAC_Q: s_d.dac_st_q = be16(s_q.dac_st_q,
                    avs_writedata_i, avs_byteenable_i);
                strx_pkg::OFS_TXD_I: s_d.txd_i = be16(s_q.txd_i,
                    avs_writedata_i, avs_byteenable_i);
                strx_pkg::OFS_TXD_Q: s_d.txd_q = be16(s_q.txd_q,
                    avs_writedata_i, avs_byteenable_i);
                strx_pkg::OFS_RXO_I: s_d.ofs_i = be16(s_q.ofs_i,
                    avs_writedata_i, avs_byteenable_i);
                strx_pkg::OFS_RXO_Q: s_d.ofs_q = be16(s_q.ofs_q,
                    avs_writedata_i, avs_byteenable_i);
                strx_pkg::OFS_GAIN_I: s_d.gain_i = be16(s_q.gain_i,
                    avs_writedata_i, avs_byteenable_i);
                strx_pkg::OFS_GAIN_Q: s_d.gain_q = be16(s_q.gain_q,
                    avs_writedata_i, avs_byteenable_i);
                strx_pkg::OFS_CPTR: s_d.cptr = avs_writedata_i[8:0];
                strx_pkg::OFS_CDAT: begin
                    // Tap write with auto-increment of the pointer
                    s_d.cwe1 = !s_q.cptr[strx_pkg::CPTR_STAGE];
                    s_d.cwe2 = s_q.cptr[strx_pkg::CPTR_STAGE];
                    s_d.cidx = s_q.cptr[5:0];
                    s_d.cdat = avs_writedata_i[15:0];
                    s_d.cptr[5:0] = (s_q.cptr[5:0] >= strx_pkg::TAP_LAST) ?
                        6'h00 : s_q.cptr[5:0] + 6'h01;
                end
                default: s_d.cptr = s_q.cptr; // Unmapped writes ignored
            endcase
        end
        // Serial port: SCLK at MCLK/2, data changes with rising SCLK
        s_d.sclk = !s_q.sclk;
        if (!s_q.sclk) begin
            s_d.rdat = s_q.sh[31];
            s_d.rfs = (s_q.bits == 6'd17) || (s_q.bits == 6'd1);
            s_d.sh = {s_q.sh[30:0], 1'b0};
            s_d.bits = (s_q.bits != 6'h00) ? s_q.bits - 6'h01 : 6'h00;
        end
        if (f2_if.vld && s_q.ctrl[strx_pkg::CTRL_RX_EN]) begin
            s_d.sh = {corr(f2_if.i, s_q.ofs_i, s_q.gain_i),
                corr(f2_if.q, s_q.ofs_q, s_q.gain_q)};
            if (s_q.ctrl[strx_pkg::CTRL_IDENT]) begin
                s_d.sh[16] = sym_lvl;
            end
            s_d.bits = 6'd32;
        end
        // Pin is high unless carrying the symbol clock
        s_d.irq_b = s_q.ctrl[strx_pkg::CTRL_SYM_IRQ] ? !sym_lvl : 1'b1;
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            s_q <= '0;
            s_q.wreq <= 1'b1;
            s_q.ctrl <= strx_pkg::CTRL_RST;
            s_q.gain_i <= strx_pkg::GAIN_RST;
            s_q.gain_q <= strx_pkg::GAIN_RST;
            s_q.irq_b <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Decimated stream into the cascade, scaled to 16 bits
    assign dec_if.vld = s_q.dec_vld;
    assign dec_if.i = 16'(s_q.dec_i.y) <<< 6;
    assign dec_if.q = 16'(s_q.dec_q.y) <<< 6;

    // First stage: stop-band clean-up
    strx_fir u_fir1 (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .coef_we_i(s_q.cwe1),
        .coef_idx_i(s_q.cidx),
        .coef_dat_i(s_q.cdat),
        .in_if(dec_if),
        .out_if(f1_if)
    );

    // Second stage: main pulse shaping
    strx_fir u_fir2 (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .coef_we_i(s_q.cwe2),
        .coef_idx_i(s_q.cidx),
        .coef_dat_i(s_q.cdat),
        .in_if(f1_if),
        .out_if(f2_if)
    );

    assign avs_readdata_o = s_q.rdata;
    assign avs_waitrequest_o = s_q.wreq;
    assign rx_sclk_o = s_q.sclk;
    assign rx_dat_o = s_q.rdat;
    assign rx_fs_o = s_q.rfs;
    assign irq_b_o = s_q.irq_b;
    // Bypass and power-down go together: no use for one alone
    assign aaf_bypass_o = s_q.ctrl[strx_pkg::CTRL_AAF_BYP];
    assign aaf_pdn_o = s_q.ctrl[strx_pkg::CTRL_AAF_BYP];
    assign dac_i_o = s_q.dac_i;
    assign dac_q_o = s_q.dac_q;
    assign dac_vld_o = s_q.dac_vld;
    assign txf_i_o = s_q.txf_i;
    assign txf_q_o = s_q.txf_q;
    assign txf_vld_o = s_q.txf_vld;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    smp_period_a: assert property (
        smp_stb |-> ##64 smp_stb) else $error("sample period broken");
    sym_align_a: assert property (
        txf_vld_o |-> $past(smp_stb) && $past(s_q.sym_cnt) == 3'h0)
        else $error("symbol strobe off sample grid");
    phase_adv_a: assert property (
        smp_stb && s_q.phase == strx_pkg::PH_ADV_4 |=>
        s_q.sym_cnt == $past(s_q.sym_cnt) + 3'h3)
        else $error("quarter advance wrong");
    phase_ret_a: assert property (
        smp_stb && s_q.phase == strx_pkg::PH_RET_8 |=> $stable(s_q.sym_cnt))
        else $error("eighth retard wrong");
    irq_route_a: assert property (
        s_q.ctrl[strx_pkg::CTRL_SYM_IRQ] |=> irq_b_o == !$past(sym_lvl))
        else $error("symbol clock not on pin");
    dac_move_a: assert property (
        bus_done && avs_write_i && avs_address_i == strx_pkg::OFS_DAC_I &&
        s_q.ctrl[strx_pkg::CTRL_DAC_TEST] |-> ##[1:65] dac_vld_o)
        else $error("test sample not moved");
    dac_value_a: assert property (
        dac_vld_o |-> dac_i_o == $past(s_q.dac_st_i))
        else $error("test sample value lost");
    dec_rate_a: assert property (
        s_q.dec_vld |-> $past(smp_stb)) else $error("decimation rate");
    ident_lsb_a: assert property (
        f2_if.vld && s_q.ctrl[strx_pkg::CTRL_RX_EN] &&
        s_q.ctrl[strx_pkg::CTRL_IDENT] |=> s_q.sh[16] == $past(sym_lvl))
        else $error("ident bit missing");
    bus_ack_a: assert property (
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=>
        !avs_waitrequest_o) else $error("bus answer late");
    word_len_a: assert property (
        f2_if.vld && s_q.ctrl[strx_pkg::CTRL_RX_EN] |=> s_q.bits == 6'd32)
        else $error("word length");

    adv_c: cover property (smp_stb && s_q.phase == strx_pkg::PH_ADV_8);
    dac_c: cover property (dac_vld_o);
    rx_fs_c: cover property (rx_fs_o ##32 rx_fs_o);
    coef_c: cover property (s_q.cwe2);
endmodule

// ==== strx_host_model.sv ====
// Far-side model: modulator bit source and receive serial port capture
`timescale 1ns/10ps
module strx_host_model (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic sclk_i,
    input wire logic dat_i,
    input wire logic fs_i,
    output logic bit_o,
    output logic [31:0] word_o,
    output logic word_vld_o
);
    logic [31:0] sh_q; // Incoming serial bits
    logic odd_q; // Next frame sync closes the Q word
    // Constant stream keeps the decimated level steady and nonzero
    assign bit_o = 1'b1;
    ////////////////////////////////////////////////////////////////////////
    // Sample while serial clock is high; data only moves on its rise
    always_ff @(posedge clk_i) begin
        word_vld_o <= 1'b0;
        if (!rst_b_i) begin
            odd_q <= 1'b0;
        end else if (sclk_i) begin
            sh_q <= {sh_q[30:0], dat_i};
            if (fs_i) begin
                odd_q <= !odd_q;
                // I word first, so the second sync ends the pair
                if (odd_q) begin
                    word_o <= {sh_q[30:0], dat_i};
                    word_vld_o <= 1'b1;
                end
            end
        end
    end
endmodule

// ==== tb_sample_timing_and_rx_datapath.sv ====
// Self-checking bench for the sample timing and receive datapath
`timescale 1ns/10ps
module tb_sample_timing_and_rx_datapath;
    logic clk_i = 0, rst_b_i = 0, rd = 0, wr = 0, wq, bi, sc, sd, fs;
    logic irq_b, byp, pdn, dv, tv, wv;
    logic [7:0] ad = '0;
    logic [31:0] wd = '0, rdat, wo;
    logic [15:0] di, dq, ti, tq;
    int fails = 0, n_checks = 0, cyc = 0;
    strx_top strx_top_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .avs_address_i(ad), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wq), .rx_bit_i_i(bi),
        .rx_bit_q_i(bi), .rx_sclk_o(sc), .rx_dat_o(sd), .rx_fs_o(fs),
        .irq_b_o(irq_b), .aaf_bypass_o(byp), .aaf_pdn_o(pdn),
        .dac_i_o(di), .dac_q_o(dq), .dac_vld_o(dv), .txf_i_o(ti),
        .txf_q_o(tq), .txf_vld_o(tv));
    strx_host_model strx_host_model_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .sclk_i(sc), .dat_i(sd), .fs_i(fs), .bit_o(bi), .word_o(wo),
        .word_vld_o(wv));
    initial forever #25 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////////
    // Hang guard, about twice the twenty thousand or so cycles the tests need
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 40000) begin
            fails++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    // One Avalon cycle, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        ad <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do @(posedge clk_i); while (wq !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_regs();
        logic [31:0] q;
        bus(0, strx_pkg::OFS_CTRL, 0, q);
        chk("ctrl reset", 32'(strx_pkg::CTRL_RST), q);
        bus(0, 8'h3C, 0, q);
        chk("unmapped", 0, q);
        bus(1, strx_pkg::OFS_CTRL, 1 << strx_pkg::CTRL_AAF_BYP, q);
        repeat (2) @(posedge clk_i);
        chk("aaf", 3, {byp, pdn});
        $display("done regs");
    endtask
    // Gap between symbol marks on the interrupt pin, one per phase code
    task automatic t_phase();
        logic [31:0] q;
        logic [2:0] cd [5] = '{strx_pkg::PH_NONE, strx_pkg::PH_ADV_8,
            strx_pkg::PH_ADV_4, strx_pkg::PH_RET_8, strx_pkg::PH_RET_4};
        int ex [5] = '{512, 448, 384, 576, 640};
        realtime t;
        bus(1, strx_pkg::OFS_CTRL, 1 << strx_pkg::CTRL_SYM_IRQ, q);
        @(posedge irq_b); // Enabling may give a false fall; skip it
        for (int k = 0; k < 5; k++) begin
            @(negedge irq_b);
            t = $realtime;
            bus(1, strx_pkg::OFS_PHASE, 32'(cd[k]), q);
            @(negedge irq_b);
            chk("sym gap", ex[k], 32'(int'(($realtime - t) / 50)));
        end
        $display("done phase");
    endtask
    // Host writes an I and a Q sample after a strobe and checks both after the next
    task automatic t_dac();
        logic [31:0] q;
        realtime t;
        int n;
        bus(1, strx_pkg::OFS_CTRL, 1 << strx_pkg::CTRL_DAC_TEST, q);
        for (int k = 0; k < 2; k++) begin
            @(posedge dv);
            bus(1, strx_pkg::OFS_DAC_I, 32'h0000_1234 + k, q);
            t = $realtime;
            bus(1, strx_pkg::OFS_DAC_Q, 32'h0000_5678 + k, q);
            @(posedge dv);
            n = int'(($realtime - t) / 50);
            bus(0, strx_pkg::OFS_DAC_I, 0, q);
            chk("dac i", 32'h0000_1234 + k, di);
            chk("dac q", 32'h0000_5678 + k, dq);
            chk("dac lat", 1, n >= 1 && n <= 65);
            chk("dac rd", 32'h0000_1234 + k, q);
        end
        $display("done dac");
    endtask
    task automatic t_txd();
        logic [31:0] q;
        realtime t;
        bus(1, strx_pkg::OFS_CTRL, 1 << strx_pkg::CTRL_TX_DIRECT, q);
        bus(1, strx_pkg::OFS_TXD_I, 32'h0000_7FFE, q);
        bus(1, strx_pkg::OFS_TXD_Q, 32'h0000_8001, q);
        @(posedge tv);
        t = $realtime;
        @(posedge tv);
        chk("tx gap", 512, 32'(int'(($realtime - t) / 50)));
        @(posedge clk_i);
        chk("txd q", 32'h0000_8001, tq);
        chk("txd i", 32'h0000_7FFE, ti);
        $display("done txd");
    endtask
    // Opposite gains on equal inputs, then the identification bit
    task automatic t_rx();
        logic [31:0] q;
        int n;
        bus(1, strx_pkg::OFS_GAIN_I, 32'h0000_4000, q);
        bus(1, strx_pkg::OFS_GAIN_Q, 32'h0000_C000, q);
        bus(1, strx_pkg::OFS_CTRL, 1 << strx_pkg::CTRL_RX_EN, q);
        repeat (200) @(posedge wv);
        @(posedge clk_i);
        chk("rx live", 1, wo[31:16] != 0);
        chk("rx inv", 1, 16'(wo[31:16] + wo[15:0]) >= 16'hFFFF ||
            16'(wo[31:16] + wo[15:0]) == 0);
        bus(1, strx_pkg::OFS_CTRL, 32'h0000_0011, q);
        repeat (4) @(posedge wv);
        n = 0;
        repeat (16) begin
            @(posedge wv);
            @(posedge clk_i);
            n += int'(wo[16]);
        end
        chk("ident", 8, n);
        $display("done rx");
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_regs();
        t_phase();
        t_dac();
        t_txd();
        t_rx();
        end_of_test();
    end
endmodule
